// file: src/otppv_defines.vh
/*
 * Constants of the fuse program-and-verify controller: device register
 * addresses, burn keys, threshold codes, timing, controller register map.
 * Assumes a 40 MHz system clock.
 */
`ifndef OTPPV_DEFINES_VH
`define OTPPV_DEFINES_VH

// ****
// device register addresses
// ****
`define OTPPV_DEV_MEM_FIRST 8'h00
`define OTPPV_DEV_MISR_FIRST 8'h02
`define OTPPV_DEV_MISR_LAST 8'h1D
`define OTPPV_DEV_CFG_FIRST 8'h0A
`define OTPPV_DEV_SIG 8'h1E
`define OTPPV_DEV_ENGINE 8'h23
`define OTPPV_DEV_KEY1 8'h62
`define OTPPV_DEV_KEY2 8'h63
`define OTPPV_DEV_ANGLE 8'h20
`define OTPPV_DEV_LOCK 8'h1D
`define OTPPV_LOCK_MASK 8'h80

// ****
// codes written to the device
// ****
`define OTPPV_ENGINE_RESET 8'h20
`define OTPPV_THR_GUARD 8'h40
`define OTPPV_THR_NORMAL 8'h00
`define OTPPV_KEY1_VAL 8'h70
`define OTPPV_KEY2_VAL 8'h51
`define OTPPV_SIG_CLEAR 8'h00
`define OTPPV_MISR_POLY 8'h1D

// ****
// timing
// ****
`define OTPPV_CLK_HZ 40000000
`define OTPPV_BURN_MS 10
`define OTPPV_REFRESH_MS 5
`define OTPPV_BURN_CYC (`OTPPV_BURN_MS * (`OTPPV_CLK_HZ / 1000))
`define OTPPV_REFRESH_CYC (`OTPPV_REFRESH_MS * (`OTPPV_CLK_HZ / 1000))

// ****
// controller register map (byte addresses)
// ****
`define OTPPV_REG_CTRL 8'h00
`define OTPPV_REG_STATUS 8'h04
`define OTPPV_REG_ANGLE 8'h08
`define OTPPV_REG_SIG 8'h0C
`define OTPPV_REG_IMG_BASE 8'h80
`define OTPPV_CMD_CAL1 0
`define OTPPV_CMD_CAL2 1
`define OTPPV_CMD_CHECK 2
`define OTPPV_CMD_PROG 3
`define OTPPV_ST_BUSY 0
`define OTPPV_ST_DONE 1
`define OTPPV_ST_CMP_FAIL 2
`define OTPPV_ST_REFRESH_FAIL 3
`define OTPPV_ST_PROG_FAIL 4
`define OTPPV_ST_BURNED 5
`define OTPPV_ST_REFUSED 6
`define OTPPV_RESP_OKAY 2'h0
`define OTPPV_RESP_SLVERR 2'h2

`endif

// file: src/otppv_misr.v
/*
 * Signature accumulator for the fuse self-test byte.
 * Assumes the caller clears it before a sweep and feeds bytes in
 * ascending address order, one per enable.
 */
`timescale 1ns/100ps
`include "otppv_defines.vh"

module otppv_misr (
    input wire sys_clk_i,
    input wire rst_i,
    input wire clr_i,
    input wire en_i,
    input wire [7:0] din_i,
    output reg [7:0] sig_o
);

    wire [7:0] shifted;
    assign shifted = {sig_o[6:0], 1'b0} ^ din_i; // RULE8

    always @(posedge sys_clk_i) begin
        if (rst_i || clr_i) begin
            sig_o <= 8'h00; // RULE8
        end else if (en_i) begin
            if (sig_o[7]) begin
                sig_o <= shifted ^ `OTPPV_MISR_POLY; // RULE9
            end else begin
                sig_o <= shifted;
            end
        end
    end

endmodule

// file: src/otppv_timer.v
/*
 * One-shot wait timer counting system clock cycles.
 * Assumes start_i is a one-cycle pulse; done_o pulses once at expiry.
 */
`timescale 1ns/100ps

module otppv_timer (
    input wire sys_clk_i,
    input wire rst_i,
    input wire start_i,
    input wire [23:0] cycles_i,
    output reg done_o
);

    reg [23:0] count;
    reg running;

    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            count <= 24'h000000;
            running <= 1'b0;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (start_i) begin
                count <= cycles_i;
                running <= 1'b1;
            end else if (running) begin
                if (count <= 24'h000001) begin
                    running <= 1'b0;
                    done_o <= 1'b1;
                end else begin
                    count <= count - 24'h000001;
                end
            end
        end
    end

endmodule

// file: src/otppv_ctrl.v
/*
 * Programming station controller: AXI4-Lite commands make it work the
 * sensor registers to calibrate, program and verify its fuses.
 * Assumes a device register port with a held request and a one-cycle
 * acknowledge; the device is in communication mode while unlocked.
 */
`timescale 1ns/100ps
`include "otppv_defines.vh"

// What this block does
// RULE1 - device starts in communication mode while unlocked; programming happens there
// RULE2 - write 0x20 to 0x23 to reset the angle engine at start position
// RULE3 - read measured angle at start and stop; software derives calibration values
// RULE4 - write config 0x0A..0x1E, read back and compare every byte
// RULE5 - write settings with lock bit, then read 0x00..0x1D
// RULE6 - fuse self-test compares stored signature byte with content signature
// RULE7 - signature covers bytes 0x02..0x1D in ascending order
// RULE8 - accumulator from zero, shift left, xor byte, keep eight bits
// RULE9 - if old bit 7 set, also xor with 29
// RULE10 - write signature to 0x1E, rewrite all, read back and compare
// RULE11 - burn only by 0x70 to 0x62 then 0x51 to 0x63 after good compare
// RULE12 - burn completes in 10 ms; no access before then
// RULE13 - clear 0x1E with 0x00 before each verification refresh
// RULE14 - 0x40 to 0x23 selects guard band threshold for first verify
// RULE15 - 0x00 to 0x23 restores normal threshold for second verify
// RULE16 - shadow reload within 5 ms; wait before reading
// RULE17 - refresh good only if 0x1E equals computed signature
// RULE18 - any refreshed mismatch means bad part; never burn again
// RULE19 - guard band threshold used only in the post-burn verify
// RULE20 - once locked, device starts in functional mode after reset
// RULE21 - abort without burn key on any pre-burn compare mismatch
module otppv_ctrl #(
    parameter BURN_CYC = `OTPPV_BURN_CYC,
    parameter REFRESH_CYC = `OTPPV_REFRESH_CYC
) (
    input wire sys_clk_i,
    input wire rst_i,
    input wire [7:0] s_axi_awaddr_i,
    input wire s_axi_awvalid_i,
    output wire s_axi_awready_o,
    input wire [31:0] s_axi_wdata_i,
    input wire [3:0] s_axi_wstrb_i,
    input wire s_axi_wvalid_i,
    output wire s_axi_wready_o,
    output reg [1:0] s_axi_bresp_o,
    output reg s_axi_bvalid_o,
    input wire s_axi_bready_i,
    input wire [7:0] s_axi_araddr_i,
    input wire s_axi_arvalid_i,
    output wire s_axi_arready_o,
    output reg [31:0] s_axi_rdata_o,
    output reg [1:0] s_axi_rresp_o,
    output reg s_axi_rvalid_o,
    input wire s_axi_rready_i,
    output reg dev_req_o,
    output reg dev_we_o,
    output reg [7:0] dev_addr_o,
    output reg [7:0] dev_wdata_o,
    input wire dev_ack_i,
    input wire [7:0] dev_rdata_i
);

    // ****
    // states and storage
    // ****
    localparam ST_IDLE = 5'b00001;
    localparam ST_SETUP = 5'b00010;
    localparam ST_ISSUE = 5'b00100;
    localparam ST_ACC = 5'b01000;
    localparam ST_WAIT = 5'b10000;

    reg [4:0] state;
    reg [4:0] phase;
    reg [7:0] img [0:31];
    reg [15:0] angle_t1;
    reg [15:0] angle_t2;
    reg [7:0] angle_lo;
    reg [6:0] status;
    reg timer_start;
    reg misr_clr;
    wire misr_en;
    wire [7:0] sig;
    wire timer_done;

    // ****
    // expected byte for an address
    // ****
    function [7:0] exp_byte;
        input [7:0] a;
        input lock;
        input fin;
        input [7:0] img_b;
        input [7:0] sig_b;
        begin
            if (a == `OTPPV_DEV_SIG) begin
                exp_byte = fin ? sig_b : img_b;
            end else if (lock && a == `OTPPV_DEV_LOCK) begin
                exp_byte = img_b | `OTPPV_LOCK_MASK;
            end else begin
                exp_byte = img_b;
            end
        end
    endfunction

    // ****
    // phase table
    // ****
    reg ph_we, ph_cst, ph_cmp, ph_lock, ph_fin, ph_misr, ph_ang, ph_end;
    reg [1:0] ph_wait;
    reg [7:0] ph_first, ph_last, ph_cval;

    always @* begin
        ph_we = 1'b1;
        ph_cst = 1'b1;
        ph_cmp = 1'b0;
        ph_lock = 1'b1;
        ph_fin = 1'b1;
        ph_misr = 1'b0;
        ph_ang = 1'b0;
        ph_end = 1'b0;
        ph_wait = 2'd0;
        ph_first = `OTPPV_DEV_CFG_FIRST;
        ph_last = `OTPPV_DEV_SIG;
        ph_cval = 8'h00;
        case (phase)
            5'd0: begin
                ph_cst = 1'b0; // RULE5
                ph_fin = 1'b0;
            end
            5'd1: begin
                ph_we = 1'b0; // RULE5
                ph_misr = 1'b1;
                ph_first = `OTPPV_DEV_MEM_FIRST;
                ph_last = `OTPPV_DEV_MISR_LAST;
            end
            5'd2: begin
                ph_cst = 1'b0; // RULE10
                ph_first = `OTPPV_DEV_SIG;
            end
            5'd3: ph_cst = 1'b0; // RULE10
            5'd4: begin
                ph_we = 1'b0; // RULE10
                ph_cmp = 1'b1;
            end
            5'd5: begin
                ph_first = `OTPPV_DEV_KEY1; // RULE11
                ph_last = `OTPPV_DEV_KEY1;
                ph_cval = `OTPPV_KEY1_VAL;
            end
            5'd6: begin
                ph_first = `OTPPV_DEV_KEY2; // RULE11
                ph_last = `OTPPV_DEV_KEY2;
                ph_cval = `OTPPV_KEY2_VAL;
            end
            5'd7: ph_wait = 2'd1; // RULE12
            5'd8, 5'd12: begin
                ph_first = `OTPPV_DEV_SIG; // RULE13
                ph_cval = `OTPPV_SIG_CLEAR;
            end
            5'd9: begin
                ph_first = `OTPPV_DEV_ENGINE; // RULE14 RULE19
                ph_last = `OTPPV_DEV_ENGINE;
                ph_cval = `OTPPV_THR_GUARD;
            end
            5'd13: begin
                ph_first = `OTPPV_DEV_ENGINE; // RULE15
                ph_last = `OTPPV_DEV_ENGINE;
                ph_cval = `OTPPV_THR_NORMAL;
            end
            5'd10, 5'd14: ph_wait = 2'd2; // RULE16
            5'd11: begin
                ph_we = 1'b0;
                ph_cmp = 1'b1;
            end
            5'd15: begin
                ph_we = 1'b0;
                ph_cmp = 1'b1;
                ph_end = 1'b1;
            end
            5'd16: begin
                ph_cst = 1'b0; // RULE4
                ph_lock = 1'b0;
                ph_fin = 1'b0;
            end
            5'd17: begin
                ph_we = 1'b0; // RULE4
                ph_cmp = 1'b1;
                ph_lock = 1'b0;
                ph_fin = 1'b0;
                ph_end = 1'b1;
            end
            5'd18: begin
                ph_first = `OTPPV_DEV_ENGINE; // RULE2
                ph_last = `OTPPV_DEV_ENGINE;
                ph_cval = `OTPPV_ENGINE_RESET;
            end
            5'd19, 5'd20: begin
                ph_we = 1'b0; // RULE3
                ph_ang = 1'b1;
                ph_end = 1'b1;
                ph_first = `OTPPV_DEV_ANGLE;
                ph_last = `OTPPV_DEV_ANGLE + 8'h01;
            end
            default: ph_end = 1'b1;
        endcase
    end

    // ****
    // AXI4-Lite slave
    // ****
    reg aw_full, w_full;
    reg [7:0] aw_addr;
    reg [31:0] w_data;
    reg [3:0] w_strb;
    reg cmd_wr;
    wire do_write;

    assign s_axi_awready_o = ~aw_full;
    assign s_axi_wready_o = ~w_full;
    assign s_axi_arready_o = ~s_axi_rvalid_o;
    assign do_write = aw_full && w_full && !s_axi_bvalid_o;

    always @(posedge sys_clk_i) begin
        cmd_wr <= 1'b0;
        if (rst_i) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= `OTPPV_RESP_OKAY;
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o <= 32'h00000000;
            s_axi_rresp_o <= `OTPPV_RESP_OKAY;
        end else begin
            if (s_axi_awvalid_i && !aw_full) begin
                aw_full <= 1'b1;
                aw_addr <= s_axi_awaddr_i;
            end
            if (s_axi_wvalid_i && !w_full) begin
                w_full <= 1'b1;
                w_data <= s_axi_wdata_i;
                w_strb <= s_axi_wstrb_i;
            end
            if (do_write) begin
                aw_full <= 1'b0;
                w_full <= 1'b0;
                s_axi_bvalid_o <= 1'b1;
                s_axi_bresp_o <= `OTPPV_RESP_OKAY;
                if (aw_addr == `OTPPV_REG_CTRL) begin
                    cmd_wr <= w_strb[0];
                end else if (!aw_addr[7] && aw_addr[7:2] != 6'h01 &&
                    aw_addr[7:2] != 6'h02 && aw_addr[7:2] != 6'h03) begin
                    s_axi_bresp_o <= `OTPPV_RESP_SLVERR;
                end
            end else if (s_axi_bvalid_o && s_axi_bready_i) begin
                s_axi_bvalid_o <= 1'b0;
            end
            if (s_axi_arvalid_i && !s_axi_rvalid_o) begin
                s_axi_rvalid_o <= 1'b1;
                s_axi_rresp_o <= `OTPPV_RESP_OKAY;
                s_axi_rdata_o <= 32'h00000000;
                if (s_axi_araddr_i[7]) begin
                    s_axi_rdata_o <= {24'h000000, img[s_axi_araddr_i[6:2]]};
                end else begin
                    case (s_axi_araddr_i[7:2])
                        6'h00: s_axi_rdata_o <= 32'h00000000;
                        6'h01: s_axi_rdata_o <= {25'h0000000, status};
                        6'h02: s_axi_rdata_o <= {angle_t2, angle_t1};
                        6'h03: s_axi_rdata_o <= {24'h000000, sig};
                        default: s_axi_rresp_o <= `OTPPV_RESP_SLVERR;
                    endcase
                end
            end else if (s_axi_rvalid_o && s_axi_rready_i) begin
                s_axi_rvalid_o <= 1'b0;
            end
        end
    end

    // image bytes have no reset; software loads them before a command
    always @(posedge sys_clk_i) begin
        if (do_write && aw_addr[7] && w_strb[0]) begin
            img[aw_addr[6:2]] <= w_data[7:0];
        end
    end

    // ****
    // sequencer
    // ****
    wire [7:0] img_b;
    wire [7:0] exp_b;
    wire mismatch;

    assign img_b = img[dev_addr_o[4:0]];
    assign exp_b = exp_byte(dev_addr_o, ph_lock, ph_fin, img_b, sig);
    assign mismatch = ph_cmp && (dev_rdata_i != exp_b);
    assign misr_en = (state == ST_ACC) && dev_ack_i && ph_misr &&
        (dev_addr_o >= `OTPPV_DEV_MISR_FIRST); // RULE7

    always @(posedge sys_clk_i) begin
        timer_start <= 1'b0;
        misr_clr <= 1'b0;
        if (rst_i) begin
            state <= ST_IDLE;
            phase <= 5'd0;
            status <= 7'h00;
            angle_t1 <= 16'h0000;
            angle_t2 <= 16'h0000;
            angle_lo <= 8'h00;
            dev_req_o <= 1'b0;
            dev_we_o <= 1'b0;
            dev_addr_o <= 8'h00;
            dev_wdata_o <= 8'h00;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (cmd_wr) begin
                        status[`OTPPV_ST_DONE] <= 1'b0;
                        status[`OTPPV_ST_REFUSED] <= 1'b0;
                        status[`OTPPV_ST_CMP_FAIL] <= 1'b0;
                        state <= ST_SETUP;
                        status[`OTPPV_ST_BUSY] <= 1'b1;
                        if (w_data[`OTPPV_CMD_PROG]) begin
                            if (status[`OTPPV_ST_BURNED]) begin
                                state <= ST_IDLE; // RULE18
                                status[`OTPPV_ST_BUSY] <= 1'b0;
                                status[`OTPPV_ST_REFUSED] <= 1'b1;
                            end
                            phase <= 5'd0;
                            misr_clr <= 1'b1;
                        end else if (w_data[`OTPPV_CMD_CHECK]) begin
                            phase <= 5'd16;
                        end else if (w_data[`OTPPV_CMD_CAL2]) begin
                            phase <= 5'd20;
                        end else if (w_data[`OTPPV_CMD_CAL1]) begin
                            phase <= 5'd18;
                        end else begin
                            state <= ST_IDLE;
                            status[`OTPPV_ST_BUSY] <= 1'b0;
                        end
                    end
                end
                ST_SETUP: begin
                    dev_addr_o <= ph_first;
                    if (ph_wait != 2'd0) begin
                        timer_start <= 1'b1;
                        state <= ST_WAIT;
                    end else begin
                        state <= ST_ISSUE;
                    end
                end
                ST_ISSUE: begin
                    dev_req_o <= 1'b1;
                    dev_we_o <= ph_we;
                    dev_wdata_o <= ph_cst ? ph_cval : exp_b;
                    state <= ST_ACC;
                end
                ST_ACC: begin
                    if (dev_ack_i) begin
                        dev_req_o <= 1'b0;
                        if (ph_ang) begin
                            angle_lo <= dev_rdata_i;
                        end
                        if (mismatch) begin
                            state <= ST_IDLE; // RULE21
                            status[`OTPPV_ST_BUSY] <= 1'b0;
                            if (phase == 5'd11 || phase == 5'd15) begin
                                if (dev_addr_o == `OTPPV_DEV_SIG) begin
                                    status[`OTPPV_ST_REFRESH_FAIL] <= 1'b1; // RULE17
                                end else begin
                                    status[`OTPPV_ST_PROG_FAIL] <= 1'b1; // RULE18
                                end
                            end else begin
                                status[`OTPPV_ST_CMP_FAIL] <= 1'b1; // RULE4
                            end
                        end else if (dev_addr_o == ph_last) begin
                            if (phase == 5'd6) begin
                                status[`OTPPV_ST_BURNED] <= 1'b1;
                            end
                            if (phase == 5'd19) begin
                                angle_t1 <= {angle_lo, dev_rdata_i}; // RULE3
                            end
                            if (phase == 5'd20) begin
                                angle_t2 <= {angle_lo, dev_rdata_i}; // RULE3
                            end
                            if (ph_end) begin
                                state <= ST_IDLE;
                                status[`OTPPV_ST_BUSY] <= 1'b0;
                                status[`OTPPV_ST_DONE] <= 1'b1;
                            end else begin
                                phase <= phase + 5'd1;
                                state <= ST_SETUP;
                            end
                        end else begin
                            dev_addr_o <= dev_addr_o + 8'h01;
                            state <= ST_ISSUE;
                        end
                    end
                end
                ST_WAIT: begin
                    if (timer_done) begin
                        phase <= phase + 5'd1; // RULE12 RULE16
                        state <= ST_SETUP;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    otppv_misr u_misr (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .clr_i(misr_clr),
        .en_i(misr_en),
        .din_i(dev_rdata_i),
        .sig_o(sig)
    );

    otppv_timer u_timer (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .start_i(timer_start),
        .cycles_i(ph_wait == 2'd1 ? BURN_CYC[23:0] : REFRESH_CYC[23:0]),
        .done_o(timer_done)
    );

endmodule

// file: test/otppv_ctrl_chk.sv
/* checker for otppv_ctrl: device access order, burn key, waits, bus holds.
   assumes it sees only the controller ports, attached by bind. */
`timescale 1ns/100ps
module otppv_ctrl_chk #(
    parameter BURN_CYC = 50,
    parameter REFRESH_CYC = 30
) (
    input wire sys_clk_i,
    input wire rst_i,
    input wire [1:0] s_axi_bresp_o,
    input wire s_axi_bvalid_o,
    input wire s_axi_bready_i,
    input wire s_axi_arvalid_i,
    input wire s_axi_arready_o,
    input wire [31:0] s_axi_rdata_o,
    input wire s_axi_rvalid_o,
    input wire s_axi_rready_i,
    input wire dev_req_o,
    input wire dev_we_o,
    input wire [7:0] dev_addr_o,
    input wire [7:0] dev_wdata_o,
    input wire dev_ack_i
);
// ****
// history of device writes
// ****
wire wr_ack = dev_req_o && dev_we_o && dev_ack_i;
wire thr_wr = dev_req_o && dev_we_o && dev_addr_o == 8'h23 && dev_wdata_o != 8'h20;
reg key1;
reg burnt;
reg clr;
reg thr;
reg [23:0] quiet;
always @(posedge sys_clk_i) begin
    if (rst_i) begin
        key1 <= 1'b0;
        burnt <= 1'b0;
        clr <= 1'b0;
        thr <= 1'b0;
        quiet <= 24'h0;
    end else begin
        if (quiet != 24'h0)
            quiet <= quiet - 24'h1;
        if (wr_ack) begin
            key1 <= dev_addr_o == 8'h62 && dev_wdata_o == 8'h70;
            clr <= dev_addr_o == 8'h1E && dev_wdata_o == 8'h00;
            if (dev_addr_o == 8'h63) begin
                burnt <= 1'b1;
                quiet <= BURN_CYC - 1;
            end
            if (thr_wr) begin
                thr <= 1'b1;
                quiet <= REFRESH_CYC - 1;
            end
        end
    end
end
default clocking cb @(posedge sys_clk_i); endclocking
default disable iff (rst_i);
req_hold_a:
    assert property (dev_req_o && !dev_ack_i |=> dev_req_o
        && $stable({dev_we_o, dev_addr_o, dev_wdata_o})) else $error("request moved");
req_drop_a:
    assert property (dev_req_o && dev_ack_i |=> !dev_req_o) else $error("request held");
key_order_a:
    assert property (dev_req_o && dev_we_o && dev_addr_o == 8'h63 |->
        key1 && dev_wdata_o == 8'h51) else $error("bad second key");
quiet_wait_a:
    assert property (dev_req_o |-> quiet == 24'h0) else $error("access during wait");
sig_clear_a:
    assert property (thr_wr |-> clr) else $error("signature not cleared");
guard_first_a:
    assert property (thr_wr && !thr |-> dev_wdata_o == 8'h40) else $error("no guard band");
normal_next_a:
    assert property (thr_wr && thr |-> dev_wdata_o == 8'h00) else $error("no normal level");
no_reburn_a:
    assert property (dev_req_o && dev_we_o && dev_addr_o == 8'h62 |-> !burnt)
        else $error("second burn");
bresp_hold_a:
    assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o
        && $stable(s_axi_bresp_o)) else $error("write answer dropped");
read_answer_a:
    assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
        else $error("read answer late");
rdata_hold_a:
    assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o
        && $stable(s_axi_rdata_o)) else $error("read answer dropped");
cover property (wr_ack && dev_addr_o == 8'h63);
cover property (s_axi_bvalid_o && s_axi_bresp_o == 2'h2);
cover property (thr_wr && thr);
endmodule
bind otppv_ctrl otppv_ctrl_chk #(.BURN_CYC(BURN_CYC), .REFRESH_CYC(REFRESH_CYC)) chk_u (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .s_axi_bresp_o(s_axi_bresp_o),
    .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
    .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
    .s_axi_rdata_o(s_axi_rdata_o), .s_axi_rvalid_o(s_axi_rvalid_o),
    .s_axi_rready_i(s_axi_rready_i), .dev_req_o(dev_req_o), .dev_we_o(dev_we_o),
    .dev_addr_o(dev_addr_o), .dev_wdata_o(dev_wdata_o), .dev_ack_i(dev_ack_i));

// file: test/otppv_dev_model.sv
/* sensor register model: memory, fuses, burn key, shadow refresh.
   assumes a held request and answers with a one-cycle ack. */
`timescale 1ns/100ps
module otppv_dev_model (
    input wire sys_clk_i,
    input wire rst_i,
    input wire req_i,
    input wire we_i,
    input wire [7:0] addr_i,
    input wire [7:0] wdata_i,
    input wire slow_i,
    input wire corrupt_i,
    output reg ack_o,
    output reg [7:0] rdata_o,
    output reg burned_o
);
reg [7:0] mem [0:255];
reg [7:0] fuse [0:30];
reg key_ok;
integer dly;
integer i;
initial begin
    for (i = 0; i < 256; i = i + 1)
        mem[i] = i ^ 8'h5A;
    rdata_o = 8'h00;
end
always @(posedge sys_clk_i) begin
    ack_o <= 1'b0;
    rdata_o <= ~rdata_o;
    if (rst_i) begin
        dly <= 0;
        key_ok <= 1'b0;
        burned_o <= 1'b0;
    end else if (req_i && !ack_o) begin
        if (dly < (slow_i ? 3 : 0)) begin
            dly <= dly + 1;
        end else begin
            dly <= 0;
            ack_o <= 1'b1;
            if (!we_i)
                rdata_o <= mem[addr_i] ^ {7'h0, corrupt_i && addr_i == 8'h14};
            else begin
                mem[addr_i] <= wdata_i;
                key_ok <= addr_i == 8'h62 && wdata_i == 8'h70;
                // burn is instant, inside the allowed time
                if (addr_i == 8'h63 && wdata_i == 8'h51 && key_ok) begin
                    burned_o <= 1'b1;
                    for (i = 0; i < 31; i = i + 1)
                        fuse[i] <= mem[i];
                end
                if (addr_i == 8'h23 && burned_o && wdata_i != 8'h20) begin
                    for (i = 0; i < 31; i = i + 1)
                        mem[i] <= fuse[i];
                end
            end
        end
    end
end
endmodule

// file: test/otppv_ctrl_tb.sv
/* testbench for otppv_ctrl: calibrate, check, abort, program, refuse.
   assumes the device model and a behavioural signature model. */
`timescale 1ns/100ps
module otppv_ctrl_tb;
reg sys_clk_i, rst_i, awv, wv, bready, arv, rready, slow, corrupt;
reg [7:0] awaddr, araddr, m [0:31];
reg [31:0] wdata, s, d;
reg [1:0] bq;
wire awready, wready, bvalid, arready, rvalid, req, we, ack, burned;
wire [1:0] bresp, rresp;
wire [31:0] rdata;
wire [7:0] addr, wd, rd8;
integer seed, n_errors, checked, cyc, n, sig;
otppv_ctrl #(.BURN_CYC(50), .REFRESH_CYC(30)) dut_u (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awv), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arv),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .dev_req_o(req), .dev_we_o(we),
    .dev_addr_o(addr), .dev_wdata_o(wd), .dev_ack_i(ack), .dev_rdata_i(rd8));
otppv_dev_model dev_u (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .req_i(req), .we_i(we),
    .addr_i(addr), .wdata_i(wd), .slow_i(slow), .corrupt_i(corrupt), .ack_o(ack),
    .rdata_o(rd8), .burned_o(burned));
initial begin
    sys_clk_i = 0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
end
// ****
// bus tasks and compare
// ****
task wr(input [7:0] a, input [31:0] v);
    begin
        awaddr <= a; wdata <= v; awv <= 1; wv <= 1; bready <= cyc[0];
        @(posedge sys_clk_i);
        while (!(bvalid && bready)) begin
            if (awv && awready) awv <= 0;
            if (wv && wready) wv <= 0;
            if (bvalid) bready <= 1;
            @(posedge sys_clk_i);
        end
        bq = bresp;
    end
endtask
task rd(input [7:0] a, output [31:0] v);
    begin
        araddr <= a; arv <= 1; rready <= cyc[0];
        @(posedge sys_clk_i);
        while (!(rvalid && rready)) begin
            if (arv && arready) arv <= 0;
            if (rvalid) rready <= 1;
            @(posedge sys_clk_i);
        end
        v = rdata;
    end
endtask
task ck(input [31:0] g, input [31:0] e);
    begin
        checked = checked + 1;
        if (g !== e) begin
            n_errors = n_errors + 1;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    end
endtask
task run(input [31:0] c);
    begin
        slow <= $random(seed);
        wr(8'h00, c);
        s = 1;
        while (s[0]) rd(8'h04, s);
    end
endtask
task wrap_up;
    begin
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    end
endtask
always @(posedge sys_clk_i) begin
    cyc = cyc + 1;
    if (cyc == 30000) begin n_errors = n_errors + 1; wrap_up; end
end
// ****
// main sequence
// ****
initial begin
    seed = 32'he7081c32; n_errors = 0; checked = 0; cyc = 0; rst_i = 1;
    awv = 0; wv = 0; bready = 0; arv = 0; rready = 0; slow = 0; corrupt = 0;
    awaddr = 0; araddr = 0; wdata = 0;
    repeat (4) @(posedge sys_clk_i);
    rst_i <= 0;
    @(posedge sys_clk_i);
    for (n = 0; n < 32; n = n + 1) begin
        m[n] = (n < 10) ? n ^ 8'h5A : $random(seed);
        wr(8'h80 + 4 * n, {24'h0, m[n]});
    end
    run(1); run(2); rd(8'h08, d); ck(d, {2{8'h7A, 8'h7B}});
    rd(8'h00, d); ck(d, 0);
    wr(8'h40, 32'h1); ck(bq, 2);
    corrupt <= 1; run(4); ck(s[6:2], 1);
    run(8); ck({s[6:2], burned}, 2);
    corrupt <= 0; run(4); ck(s[6:1], 1);
    run(8); ck(s[6:1], 6'h11);
    m[29] = m[29] | 8'h80;
    sig = 0;
    for (n = 2; n < 30; n = n + 1)
        sig = (((sig << 1) ^ m[n]) % 256) ^ (sig >= 128 ? 29 : 0);
    rd(8'h0C, d); ck(d[7:0], sig);
    ck(dev_u.fuse[30], sig);
    ck(dev_u.fuse[29], m[29]);
    run(8); ck(s[6:5], 3);
    wrap_up;
end
endmodule
